// ===== logic/rss_consts.vh
// Purpose: constants of the reclose shot sequencer
// Assumes: 100 MHz clock, millisecond timing tick
// Notes:   times in milliseconds, counts in cycles or ticks
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
`define RSS_CLK_HZ          100000000
`define RSS_TICK_NS         1000000
`define RSS_CLK_NS          10
`define RSS_TICK_CYC        (`RSS_TICK_NS / `RSS_CLK_NS)
`define RSS_TMR_W           18
`define RSS_START_MS        18'h001F4
`define RSS_DEAD1_MS        18'h000C8
`define RSS_DEAD2_MS        18'h1D4C0
`define RSS_RECLAIM_MS      18'h02710
`define RSS_ARC_MS          18'h000C8
`define RSS_GEN_RECLAIM_MS  18'h02710
// Register offsets
`define RSS_A_CTRL          8'h00
`define RSS_A_STATUS        8'h04
`define RSS_A_START         8'h08
`define RSS_A_DEAD1         8'h0C
`define RSS_A_DEAD2         8'h10
`define RSS_A_RECLAIM       8'h14
`define RSS_A_ARC           8'h18
`define RSS_A_GEN_RECLAIM   8'h1C
// Control field positions
`define RSS_C_ENABLE        0
`define RSS_C_SHOT2_EN      1
`define RSS_C_SUP1_DISC     2
`define RSS_C_SUP2_DISC     3
`define RSS_C_SUP1_ON       4
`define RSS_C_SUP2_ON       5
`define RSS_C_GEN_LOCK      6
`define RSS_C_GEN_SKIP      7
`define RSS_C_MAN_RESET     8
`define RSS_CTRL_RESET      32'h00000073
`endif

// ===== logic/rss_sequencer.v
// Purpose: automatic reclosing shot sequencer for a feeder breaker
// Assumes: AHB-Lite register access, inputs synchronised here
// Notes:   zero-wait-state slave, response always OKAY
//
// What this block does
// - pickup raises request and first-shot, times start
// - start expiry sets running and opens breaker
// - breaker open, request gone: time dead
// - dead expiry sends close request to object
// - drop close on closed; start reclaim
// - arcing timed alongside reclaim on fault
// - arcing expiry opens, moves to shot two
// - shot two dead expiry closes breaker
// - reclaim expiry clears flags, starts general reclaim
// - request during reclaim: next shot or final
// - fault in general reclaim locks out, selectable
// - zero timers expire in the first cycle of their state
// - setting omits general reclaim after success
// - general reclaim expiry returns to ready
// - arcing and discrimination exclusive per shot
// - arcing starts on request; reclaim continues
// - arcing time accumulates within a shot
// - reclaim without arcing limit means success
// - request during discrimination halts, manual reset
// - follower held open until successful reclaim
// - lockout held until manual reset
// - five requests, one highest priority
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "rss_consts.vh"
module rss_sequencer (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hsel,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [4:0]  reclose_request,
   input  wire        breaker_open,
   input  wire        breaker_closed,
   input  wire        manual_reset,
   output reg         open_command,
   output reg         close_command,
   output reg         request_one_flag,
   output reg  [4:0]  request_flag,
   output reg         sequence_running,
   output reg         first_shot_active,
   output reg         second_shot_active,
   output reg         general_reclaim_interval,
   output reg         lockout,
   output reg         follower_hold_open,
   output reg         follower_close_permit
);

localparam S_READY   = 4'h0;
localparam S_START   = 4'h1;
localparam S_OPEN    = 4'h2;
localparam S_DEAD    = 4'h3;
localparam S_CLOSE   = 4'h4;
localparam S_RECLAIM = 4'h5;
localparam S_GEN     = 4'h6;
localparam S_FINAL   = 4'h7;
localparam S_LOCK    = 4'h8;
localparam S_HALT    = 4'h9;

////////////////////////////////////////////////////////////////////
// Input synchronisers
reg  [7:0]  sync_a;
reg  [7:0]  sync_b;
always @(posedge clk) begin
   if (!rst_n) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
   end else begin
      sync_a <= {manual_reset, breaker_closed, breaker_open, reclose_request};
      sync_b <= sync_a;
   end
end
wire [4:0] req   = sync_b[4:0];
wire       br_op = sync_b[5];
wire       br_cl = sync_b[6];
wire       m_rst = sync_b[7];
wire       any_req = |req;

function [4:0] rss_prio;
   input [4:0] r;
   begin
      rss_prio = r & (~r + 5'h01);
   end
endfunction

////////////////////////////////////////////////////////////////////
// Millisecond tick
reg  [16:0] div_cnt;
reg         tick;
always @(posedge clk) begin
   if (!rst_n) begin
      div_cnt <= 17'h00000;
      tick    <= 1'b0;
   end else if (div_cnt == (`RSS_TICK_CYC - 1)) begin
      div_cnt <= 17'h00000;
      tick    <= 1'b1;
   end else begin
      div_cnt <= div_cnt + 17'h00001;
      tick    <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////
// Registers over AHB-Lite
reg  [31:0] ctrl;
reg  [17:0] t_start;
reg  [17:0] t_dead1;
reg  [17:0] t_dead2;
reg  [17:0] t_reclaim;
reg  [17:0] t_arc;
reg  [17:0] t_gen;
reg         wr_pend;
reg  [7:0]  wr_addr;
reg  [3:0]  state;
// Zero-wait slave: every transfer taken at once
wire        addr_ph = hsel & hready & htrans[1];
wire [31:0] status;

always @(posedge clk) begin
   if (!rst_n) begin
      ctrl      <= `RSS_CTRL_RESET;
      t_start   <= `RSS_START_MS;
      t_dead1   <= `RSS_DEAD1_MS;
      t_dead2   <= `RSS_DEAD2_MS;
      t_reclaim <= `RSS_RECLAIM_MS;
      t_arc     <= `RSS_ARC_MS;
      t_gen     <= `RSS_GEN_RECLAIM_MS;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
   end else begin
      // Write data follows its address by one cycle
      wr_pend <= addr_ph & hwrite;
      wr_addr <= haddr[7:0];
      ctrl[`RSS_C_MAN_RESET] <= 1'b0;
      if (wr_pend) begin
         case (wr_addr)
            `RSS_A_CTRL: begin
               ctrl <= {23'h000000, hwdata[8:0]};
               if (hwdata[`RSS_C_SUP1_ON] & ~hwdata[`RSS_C_SUP1_DISC])
                  ctrl[`RSS_C_SUP1_DISC] <= 1'b0;
            end
            `RSS_A_START:       t_start   <= hwdata[17:0];
            `RSS_A_DEAD1:       t_dead1   <= hwdata[17:0];
            `RSS_A_DEAD2:       t_dead2   <= hwdata[17:0];
            `RSS_A_RECLAIM:     t_reclaim <= hwdata[17:0];
            `RSS_A_ARC:         t_arc     <= hwdata[17:0];
            `RSS_A_GEN_RECLAIM: t_gen     <= hwdata[17:0];
            default: ;
         endcase
      end
      // Read data registered for the data phase
      if (addr_ph & ~hwrite) begin
         case (haddr[7:0])
            `RSS_A_CTRL:        hrdata <= ctrl;
            `RSS_A_STATUS:      hrdata <= status;
            `RSS_A_START:       hrdata <= {14'h0000, t_start};
            `RSS_A_DEAD1:       hrdata <= {14'h0000, t_dead1};
            `RSS_A_DEAD2:       hrdata <= {14'h0000, t_dead2};
            `RSS_A_RECLAIM:     hrdata <= {14'h0000, t_reclaim};
            `RSS_A_ARC:         hrdata <= {14'h0000, t_arc};
            `RSS_A_GEN_RECLAIM: hrdata <= {14'h0000, t_gen};
            default:            hrdata <= 32'h00000000;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////
// Sequencer
reg  [17:0] tmr;
reg  [17:0] arc_acc;
reg         shot2;
wire        lock_req = m_rst | ctrl[`RSS_C_MAN_RESET];
wire        sup_on   = shot2 ? ctrl[`RSS_C_SUP2_ON] : ctrl[`RSS_C_SUP1_ON];
wire        sup_disc = shot2 ? ctrl[`RSS_C_SUP2_DISC] : ctrl[`RSS_C_SUP1_DISC];
wire [17:0] dead_lim = shot2 ? t_dead2 : t_dead1;
// Only two shots: shot two has no successor
wire        more_shot = ~shot2 & ctrl[`RSS_C_SHOT2_EN];

assign status = {16'h0000, 4'h0, state, lockout, general_reclaim_interval,
                 second_shot_active, first_shot_active, sequence_running,
                 close_command, open_command, shot2};

// zero or reached limit counts as expired
function rss_done;
   input [17:0] t;
   input [17:0] lim;
   begin
      rss_done = (t >= lim);
   end
endfunction

always @(posedge clk) begin
   if (!rst_n) begin
      state                    <= S_READY;
      tmr                      <= 18'h00000;
      arc_acc                  <= 18'h00000;
      shot2                    <= 1'b0;
      open_command             <= 1'b0;
      close_command            <= 1'b0;
      request_one_flag         <= 1'b0;
      request_flag             <= 5'h00;
      sequence_running         <= 1'b0;
      first_shot_active        <= 1'b0;
      second_shot_active       <= 1'b0;
      general_reclaim_interval <= 1'b0;
      lockout                  <= 1'b0;
      follower_hold_open       <= 1'b0;
      follower_close_permit    <= 1'b0;
   end else begin
      if (tick && tmr != 18'h3FFFF)
         tmr <= tmr + 18'h00001;
      request_one_flag <= request_flag[0];
      if (|(req & (request_flag - 5'h01)) && request_flag != 5'h00)
         request_flag <= rss_prio(req);
      case (state)
         S_READY: begin
            tmr <= 18'h00000;
            arc_acc <= 18'h00000;
            shot2 <= 1'b0;
            if (ctrl[`RSS_C_ENABLE] & any_req) begin
               request_flag      <= rss_prio(req);
               first_shot_active <= 1'b1;
               follower_close_permit <= 1'b0;
               state             <= S_START;
            end
         end
         S_START: begin
            if (rss_done(tmr, t_start)) begin
               sequence_running   <= 1'b1;
               open_command       <= 1'b1;
               follower_hold_open <= 1'b1;
               state              <= S_OPEN;
            end else if (~any_req) begin
               // Request gone before start delay: abandon
               request_flag      <= 5'h00;
               first_shot_active <= 1'b0;
               state             <= S_READY;
            end
         end
         S_OPEN: begin
            tmr <= 18'h00000;
            if (br_op & ~any_req) begin
               open_command <= 1'b0;
               state        <= S_DEAD;
            end
         end
         S_DEAD: begin
            if (rss_done(tmr, dead_lim)) begin
               close_command <= 1'b1;
               state         <= S_CLOSE;
            end
         end
         S_CLOSE: begin
            tmr     <= 18'h00000;
            arc_acc <= 18'h00000;
            if (br_cl) begin
               close_command <= 1'b0;
               state         <= S_RECLAIM;
            end
         end
         S_RECLAIM: begin
            if (tick & any_req & sup_on & ~sup_disc)
               arc_acc <= arc_acc + 18'h00001;
            if (sup_on & sup_disc & any_req &
                ~rss_done(tmr, t_arc)) begin
               state            <= S_HALT;
               lockout          <= 1'b1;
               sequence_running <= 1'b0;
            end else if (any_req & (~sup_on | sup_disc |
                         rss_done(arc_acc, t_arc))) begin
               if (more_shot) begin
                  shot2              <= 1'b1;
                  open_command       <= 1'b1;
                  first_shot_active  <= 1'b0;
                  second_shot_active <= 1'b1;
                  state              <= S_OPEN;
               end else begin
                  state <= S_FINAL;
               end
            end else if (rss_done(tmr, t_reclaim)) begin
               sequence_running   <= 1'b0;
               first_shot_active  <= 1'b0;
               second_shot_active <= 1'b0;
               request_flag       <= 5'h00;
               follower_hold_open <= 1'b0;
               follower_close_permit <= 1'b1;
               tmr <= 18'h00000;
               if (ctrl[`RSS_C_GEN_SKIP]) begin
                  state <= S_READY;
               end else begin
                  general_reclaim_interval <= 1'b1;
                  state <= S_GEN;
               end
            end
         end
         S_GEN: begin
            if (any_req & ctrl[`RSS_C_GEN_LOCK]) begin
               general_reclaim_interval <= 1'b0;
               state <= S_FINAL;
            end else if (rss_done(tmr, t_gen)) begin
               general_reclaim_interval <= 1'b0;
               state <= S_READY;
            end
         end
         S_FINAL: begin
            open_command       <= 1'b1;
            sequence_running   <= 1'b0;
            first_shot_active  <= 1'b0;
            second_shot_active <= 1'b0;
            request_flag       <= 5'h00;
            lockout            <= 1'b1;
            // follower kept open, no close permit
            follower_hold_open    <= 1'b1;
            follower_close_permit <= 1'b0;
            state              <= S_LOCK;
         end
         S_LOCK, S_HALT: begin
            // Trip withdrawn once breaker reports open
            if (br_op)
               open_command <= 1'b0;
            if (lock_req) begin
               open_command       <= 1'b0;
               lockout            <= 1'b0;
               follower_hold_open <= 1'b0;
               first_shot_active  <= 1'b0;
               second_shot_active <= 1'b0;
               request_flag       <= 5'h00;
               state              <= S_READY;
            end
         end
         default: state <= S_READY;
      endcase
   end
end

endmodule // rss_sequencer

// ===== testbench/rss_sequencer_assertions.sv
// Purpose: port checks for the reclose shot sequencer
// Assumes: status inputs pass two sync flops in the design
// Notes:   windows sized for zero timer settings
`timescale 1ns/1ns
module rss_sequencer_assertions (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic [4:0] request_flag,
   input wire logic       breaker_open,
   input wire logic       breaker_closed,
   input wire logic       open_command,
   input wire logic       close_command,
   input wire logic       sequence_running,
   input wire logic       first_shot_active,
   input wire logic       second_shot_active,
   input wire logic       follower_hold_open,
   input wire logic       follower_close_permit,
   input wire logic       lockout
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_close_seen;
      close_command && breaker_closed;
   endsequence
   sequence s_close_gone;
      ##[1:5] !close_command;
   endsequence
   ////////////////////////////////////////////////////////////
   chk_close_drop: assert property (s_close_seen |-> s_close_gone)
      else $error("close not withdrawn");
   chk_run_opens: assert property ($rose(sequence_running) |-> ##[0:2] open_command)
      else $error("running without open");
   chk_close_open: assert property ($rose(close_command) |-> breaker_open)
      else $error("close before breaker open");
   chk_shot_excl: assert property (!(first_shot_active && second_shot_active))
      else $error("two shots active");
   chk_req_onehot: assert property ($onehot0(request_flag))
      else $error("request flag not one-hot");
   chk_run_shot: assert property (sequence_running |-> first_shot_active || second_shot_active)
      else $error("running with no shot");
   chk_shot_req: assert property ($rose(first_shot_active) |-> ##[0:1] request_flag != 5'h00)
      else $error("shot without request");
   chk_follow_hold: assert property ($rose(sequence_running) |-> ##[0:2] follower_hold_open)
      else $error("follower not held");
   chk_permit_excl: assert property (follower_close_permit |-> !follower_hold_open)
      else $error("follower permit while held");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   chk_lock_idle: assert property (lockout |-> !sequence_running && !close_command)
      else $error("lockout with sequence active");
endmodule // rss_sequencer_assertions
bind rss_sequencer rss_sequencer_assertions u_chk (.clk(clk), .rst_n(rst_n), .hreadyout(hreadyout),
   .hresp(hresp), .request_flag(request_flag), .breaker_open(breaker_open),
   .breaker_closed(breaker_closed), .open_command(open_command), .close_command(close_command),
   .sequence_running(sequence_running), .first_shot_active(first_shot_active),
   .second_shot_active(second_shot_active), .follower_hold_open(follower_hold_open),
   .follower_close_permit(follower_close_permit), .lockout(lockout));

// ===== testbench/rss_breaker_model.sv
// Purpose: breaker and object control on the far side
// Assumes: breaker starts closed
// Notes:   both status lines low while contacts travel
`timescale 1ns/1ns
module rss_breaker_model (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       open_command,
   input wire logic       close_command,
   input wire logic       close_ok,
   input wire logic [7:0] travel,
   output logic           breaker_open,
   output logic           breaker_closed
);
   logic [7:0] cnt;
   logic       moving;
   logic       to_open;
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         moving <= 1'b0;
         to_open <= 1'b0;
         breaker_open <= 1'b0;
         breaker_closed <= 1'b1;
      end else if (moving) begin
         cnt <= cnt + 8'h01;
         if (cnt == travel) begin
            moving <= 1'b0;
            breaker_open <= to_open;
            breaker_closed <= !to_open;
         end
      end else if (open_command && breaker_closed) begin
         moving <= 1'b1;
         to_open <= 1'b1;
         cnt <= 8'h00;
         breaker_closed <= 1'b0;
      end else if (close_command && close_ok && breaker_open) begin
         moving <= 1'b1;
         to_open <= 1'b0;
         cnt <= 8'h00;
         breaker_open <= 1'b0;
      end
   end
endmodule // rss_breaker_model

// ===== testbench/rss_sequencer_tb.sv
// Purpose: self-checking bench for the reclose shot sequencer
// Assumes: timers written zero, except a 1 ms action window
// Notes:   bench acts as protection stage and bus master
`timescale 1ns/1ns
`include "rss_consts.vh"
module rss_sequencer_tb;
   logic        clk, rst_n, hwrite, hsel, hreadyout, hresp, manual_reset, close_ok;
   logic        breaker_open, breaker_closed, open_command, close_command, request_one_flag;
   logic        sequence_running, first_shot_active, second_shot_active, lockout;
   logic        general_reclaim_interval, follower_hold_open, follower_close_permit;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  reclose_request, request_flag;
   logic [7:0]  travel;
   logic [31:0] haddr, hwdata, hrdata, rnd, rd;
   logic [4:0]  reqs[$] = '{5'h01, 5'h06, 5'h18, 5'h10};
   int          miscompares, compares, a, gen_cnt;
   rss_sequencer dut (.clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .reclose_request(reclose_request),
      .breaker_open(breaker_open), .breaker_closed(breaker_closed), .manual_reset(manual_reset),
      .open_command(open_command), .close_command(close_command), .request_one_flag(request_one_flag),
      .request_flag(request_flag), .sequence_running(sequence_running),
      .first_shot_active(first_shot_active), .second_shot_active(second_shot_active),
      .general_reclaim_interval(general_reclaim_interval), .lockout(lockout),
      .follower_hold_open(follower_hold_open), .follower_close_permit(follower_close_permit));
   rss_breaker_model u_brk (.clk(clk), .rst_n(rst_n), .open_command(open_command),
      .close_command(close_command), .close_ok(close_ok), .travel(travel),
      .breaker_open(breaker_open), .breaker_closed(breaker_closed));
   always #5 clk = ~clk;
   always @(posedge clk) if (general_reclaim_interval) gen_cnt <= gen_cnt + 1;
   ////////////////////////////////////////////////////////////
   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [4:0] prio(input logic [4:0] r);
      prio = 5'h00;
      for (int i = 4; i >= 0; i--) if (r[i]) prio = 5'h01 << i;
   endfunction
   function logic sig(input int s);
      case (s)
         0: sig = first_shot_active;
         1: sig = sequence_running;
         2: sig = breaker_open;
         3: sig = close_command;
         4: sig = breaker_closed;
         5: sig = second_shot_active;
         default: sig = lockout;
      endcase
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task wait_on(input int s, input logic v);
      int n;
      n = 0;
      while (sig(s) !== v && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk(n < 300, 1, "wait timed out");
   endtask
   task refault(input logic [4:0] r);
      wait_on(2, 1'b1);
      reclose_request <= 5'h00;
      wait_on(3, 1'b1);
      reclose_request <= r;
      wait_on(3, 1'b0);
   endtask
   task run_cycle(input logic [4:0] r, input logic slow, input logic gen);
      int g;
      g = gen_cnt;
      reclose_request <= r;
      close_ok <= !slow;
      wait_on(0, 1'b1);
      repeat (3) @(posedge clk);
      chk(request_flag, prio(r), "request flag");
      chk(request_one_flag, r[0], "request one");
      wait_on(1, 1'b1);
      chk(open_command, 1, "open command");
      wait_on(2, 1'b1);
      repeat (20) @(posedge clk);
      chk(close_command, 0, "close while request");
      reclose_request <= 5'h00;
      wait_on(3, 1'b1);
      if (slow) begin
         repeat (40) @(posedge clk);
         chk({close_command, breaker_closed}, 2'b10, "close held");
         close_ok <= 1'b1;
      end
      wait_on(4, 1'b1);
      wait_on(3, 1'b0);
      wait_on(1, 1'b0);
      repeat (4) @(posedge clk);
      chk({first_shot_active, second_shot_active, request_flag}, 0, "flags left");
      chk({lockout, open_command}, 0, "not ready");
      chk(gen_cnt > g, gen, "general reclaim");
      chk({follower_hold_open, follower_close_permit}, 2'b01, "follower permit");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {clk, rst_n, hwrite, hsel, manual_reset, close_ok, htrans, reclose_request} = 0;
      {haddr, hwdata} = 0;
      hsize = 3'b010;
      travel = 8'h03;
      rnd = 32'h4ca8c52c;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({hreadyout, sequence_running, open_command, lockout}, 4'h8, "reset outputs");
      bus(0, `RSS_A_CTRL, 0);
      chk(rd, `RSS_CTRL_RESET, "ctrl reset");
      bus(1, 32'h40, 32'hFFFFFFFF);
      bus(0, 32'h40, 0);
      chk(rd, 0, "unmapped");
      for (a = `RSS_A_START; a <= `RSS_A_GEN_RECLAIM; a += 4) begin
         rnd = lfsr(rnd);
         bus(1, a, rnd);
         bus(0, a, 0);
         chk(rd, rnd & 32'h0003FFFF, "timer value");
         bus(1, a, 0);
      end
      manual_reset <= 1'b1;
      bus(1, `RSS_A_CTRL, 32'h173);
      manual_reset <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         travel <= {4'h0, rnd[3:0]} + 8'h01;
         if (i == 2) bus(1, `RSS_A_CTRL, 32'hF3);
         run_cycle(reqs[i], i[0], i < 2);
      end
      bus(1, `RSS_A_ARC, 32'h00000001);
      bus(1, `RSS_A_CTRL, 32'h00000017);
      reclose_request <= 5'h01;
      refault(5'h01);
      repeat (4) @(posedge clk);
      chk({lockout, sequence_running, open_command, close_command, breaker_closed}, 5'h11, "halt");
      reclose_request <= 5'h00;
      repeat (8) @(posedge clk);
      chk(lockout, 1, "lockout held");
      bus(1, `RSS_A_ARC, 32'h00000000);
      bus(1, `RSS_A_CTRL, 32'h00000173);
      wait_on(6, 1'b0);
      reclose_request <= 5'h02;
      refault(5'h02);
      wait_on(5, 1'b1);
      chk({first_shot_active, open_command}, 2'b01, "second shot");
      refault(5'h02);
      wait_on(6, 1'b1);
      chk({sequence_running, second_shot_active, request_flag, open_command}, 8'h01, "final trip");
      wait_on(2, 1'b1);
      reclose_request <= 5'h00;
      repeat (6) @(posedge clk);
      chk({lockout, open_command, follower_hold_open, follower_close_permit}, 4'hA, "locked out");
      manual_reset <= 1'b1;
      wait_on(6, 1'b0);
      manual_reset <= 1'b0;
      chk({follower_hold_open, request_flag}, 0, "reset clean");
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up;
   end
endmodule // rss_sequencer_tb
